// File: src/eids_top.sv
`timescale 1ns/1ps
// constants must be known before the parameter defaults use them
`include "eids_consts.svh"
module eids_top #(
   parameter int NUM_IN     = 8,
   parameter int SETTLE_CYC = `EIDS_SETTLE_CYC
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWrStb,
   input  wire logic        regRdStb,
   output logic [15:0]      regRdata,
   // request pins, primary and alternate
   input  wire logic [7:0]  reqPinPri_n,
   input  wire logic [7:0]  reqPinAlt_n,
   // exception handling and transfer controller
   input  wire logic [7:0]  excTaken,
   input  wire logic [7:0]  xferStart,
   input  wire logic        transferDisableSelect,
   // standby
   input  wire logic        standbyActive,
   output logic             standbyExit,
   // request flags towards the exception logic
   output logic [7:0]       requestFlags,
   output logic             irq
);
   import eids_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (NUM_IN != 8) begin : g_bad_num
      $error("eids_top serves exactly eight request inputs");
   end
   if (SETTLE_CYC < 1) begin : g_bad_settle
      $error("eids_top needs a settling count of at least one");
   end

   localparam logic [31:0] SETTLE_LAST = 32'(SETTLE_CYC - 1);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   eids_top_state_t st_r;
   eids_top_state_t st_nxt;

   logic [7:0] pinLvl;
   logic [7:0] hit;
   logic [7:0] sampleEn;

   // ------------------------------------------------------------
   // per-input detectors
   // ------------------------------------------------------------
   // in standby an input is sampled only when its wake bit is set
   assign sampleEn = standbyActive ? st_r.wake[7:0] : 8'hff;

   for (genvar i = 0; i < 8; i++) begin : g_det
      eids_sense_detect u_det (
         .mclk        (mclk),
         .rst_n       (rst_n),
         .reqPinPri_n (reqPinPri_n[i]),
         .reqPinAlt_n (reqPinAlt_n[i]),
         .pinSel      (st_r.pinSel[i]),
         .sampleEn    (sampleEn[i]),
         .sense       (st_r.sense[2*i +: 2]),
         .pinLvl      (pinLvl[i]),
         .hit         (hit[i])
      );
   end

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   logic       wrSense;
   logic       wrFlags;
   logic       wrPinSel;
   logic       wrWake;
   logic       wrEvStat;
   logic       wrEvMask;
   logic       rdFlags;
   logic [7:0] swClr;
   logic [7:0] autoClr;
   logic [7:0] levelMode;
   logic       wakeHit;
   logic       wakeDone;

   // write strobes per register, plus the read strobe for the flags
   always_comb begin
      wrSense  = regWrStb && (regAddr == `EIDS_OFS_SENSE);
      wrFlags  = regWrStb && (regAddr == `EIDS_OFS_FLAGS);
      wrPinSel = regWrStb && (regAddr == `EIDS_OFS_PINSEL);
      wrWake   = regWrStb && (regAddr == `EIDS_OFS_WAKE);
      wrEvStat = regWrStb && (regAddr == `EIDS_OFS_EVSTAT);
      wrEvMask = regWrStb && (regAddr == `EIDS_OFS_EVMASK);
      rdFlags  = regRdStb && (regAddr == `EIDS_OFS_FLAGS);
   end

   // a cleared flag needs a prior read as one; a written one is ignored
   assign swClr = wrFlags ? (st_r.armed & ~regWdata[7:0]) : 8'h00;

   // per-input automatic clear sources
   for (genvar i = 0; i < 8; i++) begin : g_clr
      assign levelMode[i] = (st_r.sense[2*i +: 2] == `EIDS_SENSE_LOW);
      // level mode only lets go once the source has released the pin
      assign autoClr[i] = (excTaken[i] && levelMode[i] && pinLvl[i])
                        | (excTaken[i] && !levelMode[i])
                        | (xferStart[i] && !transferDisableSelect);
   end

   // a wake-enabled request seen while in standby
   assign wakeHit  = standbyActive && |(hit & st_r.wake[7:0]);
   assign wakeDone = (st_r.wakeState == WAKE_SETTLE) && (st_r.settleCnt == SETTLE_LAST);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt             = st_r;
      st_nxt.standbyExit = 1'b0;
      st_nxt.rdata       = 16'h0000;

      // control registers, upper select bits kept as written
      if (wrSense) begin
         st_nxt.sense = regWdata;
      end
      if (wrPinSel) begin
         st_nxt.pinSel = regWdata;
      end
      if (wrWake) begin
         st_nxt.wake = regWdata;
      end
      if (wrEvMask) begin
         st_nxt.evMask = regWdata[8:0];
      end

      // request flags: clears first, new conditions win
      st_nxt.flags = (st_r.flags & ~swClr & ~autoClr) | hit;

      // arming: a read remembers which flags showed one
      if (wrFlags) begin
         st_nxt.armed = 8'h00;
      end
      if (rdFlags) begin
         st_nxt.armed = st_r.flags;
      end

      // settling counter for the standby exit
      case (st_r.wakeState)
         WAKE_IDLE: begin
            st_nxt.settleCnt = 32'h0000_0000;
            if (wakeHit) begin
               st_nxt.wakeState = WAKE_SETTLE;
            end
         end
         WAKE_SETTLE: begin
            if (!standbyActive) begin
               // standby left by other means, drop the wait
               st_nxt.wakeState = WAKE_IDLE;
            end else if (wakeDone) begin
               st_nxt.wakeState   = WAKE_IDLE;
               st_nxt.standbyExit = 1'b1;
            end else begin
               st_nxt.settleCnt = st_r.settleCnt + 32'h0000_0001;
            end
         end
         default: begin
            st_nxt.wakeState = WAKE_IDLE;
         end
      endcase

      // event status: one-write clears, set beats clear
      if (wrEvStat) begin
         st_nxt.evStat = st_r.evStat & ~regWdata[8:0];
      end
      st_nxt.evStat[7:0] = st_nxt.evStat[7:0] | hit;
      if (st_nxt.standbyExit) begin
         st_nxt.evStat[`EIDS_EV_WAKE_BIT] = 1'b1;
      end
      st_nxt.irq = |(st_nxt.evStat & st_nxt.evMask);

      // read data stand one cycle, unmapped reads give zero
      if (regRdStb) begin
         case (regAddr)
            `EIDS_OFS_SENSE:  st_nxt.rdata = st_r.sense;
            `EIDS_OFS_FLAGS:  st_nxt.rdata = {8'h00, st_r.flags};
            `EIDS_OFS_PINSEL: st_nxt.rdata = st_r.pinSel;
            `EIDS_OFS_WAKE:   st_nxt.rdata = st_r.wake;
            `EIDS_OFS_EVSTAT: st_nxt.rdata = {7'h00, st_r.evStat};
            `EIDS_OFS_EVMASK: st_nxt.rdata = {7'h00, st_r.evMask};
            default:          st_nxt.rdata = 16'h0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r.sense       <= `EIDS_RST_SENSE;
         st_r.flags       <= `EIDS_RST_FLAGS;
         st_r.armed       <= 8'h00;
         st_r.pinSel      <= `EIDS_RST_PINSEL;
         st_r.wake        <= `EIDS_RST_WAKE;
         st_r.evStat      <= `EIDS_RST_EV;
         st_r.evMask      <= `EIDS_RST_EV;
         st_r.rdata       <= 16'h0000;
         st_r.irq         <= 1'b0;
         st_r.standbyExit <= 1'b0;
         st_r.settleCnt   <= 32'h0000_0000;
         st_r.wakeState   <= WAKE_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs, all straight from the state register
   // ------------------------------------------------------------
   assign regRdata     = st_r.rdata;
   assign requestFlags = st_r.flags;
   assign irq          = st_r.irq;
   assign standbyExit  = st_r.standbyExit;

endmodule

// File: src/eids_consts.svh
// Behaviour
// - sense code: 00 low, 01 fall, 10 rise, 11 both
// - inputs 1 and 0 sense at 3:2, 1:0
// - selected condition sets request flag n
// - zero write clears only after read-as-one
// - level mode: exception with input high clears
// - edge modes: exception handling clears flag
// - transfer start with disable-select zero clears
// - writing one never sets a flag
// - flag register bits 15:8 read zero
// - pin-select bit picks primary or alternate pin
// - wake bit zero: input ignored in standby
// - wake leaves standby after settling period
`ifndef EIDS_CONSTS_SVH
`define EIDS_CONSTS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define EIDS_OFS_SENSE   8'h00
`define EIDS_OFS_FLAGS   8'h04
`define EIDS_OFS_PINSEL  8'h08
`define EIDS_OFS_WAKE    8'h0c
`define EIDS_OFS_EVSTAT  8'h10
`define EIDS_OFS_EVMASK  8'h14

// ------------------------------------------------------------
// reset values and field layout
// ------------------------------------------------------------
`define EIDS_RST_SENSE   16'h0000
`define EIDS_RST_FLAGS   8'h00
`define EIDS_RST_PINSEL  16'h0000
`define EIDS_RST_WAKE    16'h0007
`define EIDS_RST_EV      9'h000
`define EIDS_EV_WAKE_BIT 8
`define EIDS_SENSE_LOW   2'h0
`define EIDS_SENSE_FALL  2'h1
`define EIDS_SENSE_RISE  2'h2
`define EIDS_SENSE_BOTH  2'h3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define EIDS_CLK_NS      10
`define EIDS_SETTLE_NS   10000
`define EIDS_SETTLE_CYC  ((`EIDS_SETTLE_NS + `EIDS_CLK_NS - 1) / `EIDS_CLK_NS)

`endif

// File: src/eids_pkg.sv
package eids_pkg;

   // ------------------------------------------------------------
   // types shared by the detector and the top
   // ------------------------------------------------------------
   typedef logic [1:0] eids_sense_t;

   typedef enum logic [0:0] {
      WAKE_IDLE   = 1'b0,
      WAKE_SETTLE = 1'b1
   } eids_wake_state_t;

   // detector state: two sync stages per pin plus last selected level
   typedef struct packed {
      logic [1:0] syncPri;
      logic [1:0] syncAlt;
      logic       prevLvl;
   } eids_det_state_t;

   typedef struct packed {
      logic [15:0]      sense;
      logic [7:0]       flags;
      logic [7:0]       armed;
      logic [15:0]      pinSel;
      logic [15:0]      wake;
      logic [8:0]       evStat;
      logic [8:0]       evMask;
      logic [15:0]      rdata;
      logic             irq;
      logic             standbyExit;
      logic [31:0]      settleCnt;
      eids_wake_state_t wakeState;
   } eids_top_state_t;

endpackage

// File: src/eids_sense_detect.sv
`timescale 1ns/1ps
module eids_sense_detect (
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               reqPinPri_n,
   input  wire logic               reqPinAlt_n,
   input  wire logic               pinSel,
   input  wire logic               sampleEn,
   input  wire eids_pkg::eids_sense_t sense,
   output logic                    pinLvl,
   output logic                    hit
);
   import eids_pkg::*;
   `include "eids_consts.svh"

   eids_det_state_t st_r;
   eids_det_state_t st_nxt;
   logic            selLvl;

   // pins reach logic only through the second sync stage
   assign selLvl = pinSel ? st_r.syncAlt[1] : st_r.syncPri[1];
   assign pinLvl = selLvl;

   // condition decode; a select change may look like one edge
   always_comb begin
      case (sense)
         `EIDS_SENSE_LOW:  hit = sampleEn & ~selLvl;
         `EIDS_SENSE_FALL: hit = sampleEn & st_r.prevLvl & ~selLvl;
         `EIDS_SENSE_RISE: hit = sampleEn & ~st_r.prevLvl & selLvl;
         `EIDS_SENSE_BOTH: hit = sampleEn & (st_r.prevLvl ^ selLvl);
         default:          hit = 1'b0;
      endcase
   end

   // next state: shift syncs, remember last level while sampling
   always_comb begin
      st_nxt         = st_r;
      st_nxt.syncPri = {st_r.syncPri[0], reqPinPri_n};
      st_nxt.syncAlt = {st_r.syncAlt[0], reqPinAlt_n};
      if (sampleEn) begin
         st_nxt.prevLvl = selLvl;
      end
   end

   // idle pins are high, so reset to high avoids a false edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r <= '{syncPri: 2'h3, syncAlt: 2'h3, prevLvl: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

// File: bench/eids_pin_model.sv
`timescale 1ns/1ps
module eids_pin_model (
   input  wire logic       mclk,
   output logic      [7:0] reqPinPri_n,
   output logic      [7:0] reqPinAlt_n,
   output logic      [7:0] excTaken
);
   // pins idle high on their pull-ups, no handling pending
   initial begin
      reqPinPri_n = 8'hff;
      reqPinAlt_n = 8'hff;
      excTaken    = 8'h00;
   end
   // move one pin just after an edge
   task automatic pin(input bit alt, input int n, input bit v);
      @(posedge mclk);
      if (alt) reqPinAlt_n[n] <= v;
      else reqPinPri_n[n] <= v;
   endtask
   // one cycle of exception handling for input n
   task automatic take(input int n);
      @(posedge mclk);
      excTaken[n] <= 1'b1;
      @(posedge mclk);
      excTaken[n] <= 1'b0;
   endtask
   // level source: released high before handling, else the flag is not cleared and stays set
   task automatic serve(input int n);
      pin(1'b0, n, 1'b1);
      repeat (6) @(posedge mclk);
      take(n);
   endtask
endmodule

// File: bench/eids_top_chk.sv
`timescale 1ns/1ps
`include "eids_consts.svh"
module eids_top_chk #(
   parameter int NUM_IN     = 8,
   parameter int SETTLE_CYC = 4
) (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [7:0]  regAddr,
   input wire logic        regWrStb,
   input wire logic        regRdStb,
   input wire logic [15:0] regRdata,
   input wire logic [7:0]  reqPinPri_n,
   input wire logic [7:0]  reqPinAlt_n,
   input wire logic [7:0]  excTaken,
   input wire logic [7:0]  xferStart,
   input wire logic        transferDisableSelect,
   input wire logic        standbyActive,
   input wire logic        standbyExit,
   input wire logic [7:0]  requestFlags,
   input wire logic        irq
);
   int         stbyCnt;
   logic       rdFlags;
   logic [7:0] keep;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // flags that no automatic clear source touches this cycle
   assign rdFlags = regRdStb && regAddr == `EIDS_OFS_FLAGS;
   assign keep = requestFlags & ~excTaken & ~(xferStart & {8{!transferDisableSelect}});
   // standby length; saturates so a long stay cannot wrap
   always_ff @(posedge mclk) begin
      if (!rst_n || !standbyActive) stbyCnt <= 0;
      else if (stbyCnt < 2000) stbyCnt <= stbyCnt + 1;
   end
   // six quiet cycles: no edge or level of input 0 still in the syncs
   sequence pinsHigh;
      (reqPinPri_n[0] && reqPinAlt_n[0]) [*6];
   endsequence
   rdata_idle_a: assert property (!$past(regRdStb) |-> regRdata == 16'h0000)
      else $error("read data outside read cycle");
   flags_upper_a: assert property ($past(rdFlags) |-> regRdata[15:8] == 8'h00)
      else $error("flag register upper byte not zero");
   flags_read_a: assert property ($past(rdFlags) |-> regRdata[7:0] == $past(requestFlags))
      else $error("flag read differs from flags");
   flag_hold_a: assert property (!regWrStb |=> ($past(keep) & ~requestFlags) == 8'h00)
      else $error("flag dropped without a clear");
   auto_clear_a: assert property (pinsHigh ##0 (excTaken[0] ||
         xferStart[0] && !transferDisableSelect) |=> !requestFlags[0])
      else $error("flag not cleared by handling");
   exit_pulse_a: assert property (standbyExit |=> !standbyExit)
      else $error("standby exit longer than one cycle");
   exit_settle_a: assert property (standbyExit |-> stbyCnt > SETTLE_CYC)
      else $error("standby exit before settling");
   reset_out_a: assert property ($rose(rst_n) |-> requestFlags == 8'h00 && !irq)
      else $error("outputs not clear after reset");
endmodule
bind eids_top eids_top_chk #(.NUM_IN(NUM_IN), .SETTLE_CYC(SETTLE_CYC)) eids_top_chk_i (
   .mclk, .rst_n, .regAddr, .regWrStb, .regRdStb, .regRdata, .reqPinPri_n, .reqPinAlt_n,
   .excTaken, .xferStart, .transferDisableSelect, .standbyActive, .standbyExit,
   .requestFlags, .irq);

// File: bench/eids_top_test.sv
`timescale 1ns/1ps
`include "eids_consts.svh"
module eids_top_test;
   localparam int SETTLE = 4;
   logic        mclk = 1'b0, rst_n = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
   logic        transferDisableSelect = 1'b0, standbyActive = 1'b0, standbyExit, irq;
   logic [7:0]  regAddr = 8'h00, xferStart = 8'h00, requestFlags;
   logic [7:0]  reqPinPri_n, reqPinAlt_n, excTaken;
   logic [15:0] regWdata = 16'h0000, regRdata;
   int          errors = 0, total_checks = 0;
   always #5 mclk = ~mclk;
   eids_top #(.SETTLE_CYC(SETTLE)) eids_top_i (.mclk, .rst_n, .regAddr, .regWdata,
      .regWrStb, .regRdStb, .regRdata, .reqPinPri_n, .reqPinAlt_n, .excTaken, .xferStart,
      .transferDisableSelect, .standbyActive, .standbyExit, .requestFlags, .irq);
   eids_pin_model eids_pin_model_i (.mclk, .reqPinPri_n, .reqPinAlt_n, .excTaken);
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic p(input bit alt, input int n, input bit v);
      eids_pin_model_i.pin(alt, n, v);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= v;
      regWrStb <= 1'b1;
      @(posedge mclk);
      regWrStb <= 1'b0;
   endtask
   // data stand one cycle only, so take them just after that edge
   task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string what);
      @(posedge mclk);
      regAddr  <= a;
      regRdStb <= 1'b1;
      @(posedge mclk);
      regRdStb <= 1'b0;
      #1 chk(regRdata, e, what);
   endtask
   // read arms the flags, the zero write then drops them
   task automatic clr(input logic [15:0] e);
      rdc(`EIDS_OFS_FLAGS, e, "arm");
      wr(`EIDS_OFS_FLAGS, 16'h0000);
      rdc(`EIDS_OFS_FLAGS, 16'h0000, "cleared");
   endtask
   task automatic xfer(input logic dis);
      @(posedge mclk);
      transferDisableSelect <= dis;
      xferStart <= 8'h01;
      @(posedge mclk);
      xferStart <= 8'h00;
   endtask
   task automatic t_regs();
      rdc(`EIDS_OFS_SENSE, 16'h0000, "sense reset");
      rdc(`EIDS_OFS_PINSEL, 16'h0000, "pin select reset");
      rdc(`EIDS_OFS_WAKE, 16'h0007, "wake reset");
      wr(`EIDS_OFS_SENSE, 16'h000e);
      rdc(`EIDS_OFS_SENSE, 16'h000e, "sense fields");
      wr(`EIDS_OFS_FLAGS, 16'hffff);
      rdc(`EIDS_OFS_FLAGS, 16'h0000, "flag write one");
      rdc(8'h18, 16'h0000, "unmapped");
   endtask
   // input 1 through fall, rise and both
   task automatic t_edges();
      for (int m = 1; m < 4; m++) begin
         wr(`EIDS_OFS_SENSE, 16'(m << 2));
         p(0, 1, 0);
         wt(5);
         rdc(`EIDS_OFS_FLAGS, m[0] ? 16'h0002 : 16'h0000, "fall");
         clr(m[0] ? 16'h0002 : 16'h0000);
         p(0, 1, 1);
         wt(5);
         rdc(`EIDS_OFS_FLAGS, m[1] ? 16'h0002 : 16'h0000, "rise");
         clr(m[1] ? 16'h0002 : 16'h0000);
      end
   endtask
   task automatic t_auto();
      wr(`EIDS_OFS_SENSE, 16'h0001);
      p(0, 0, 0);
      p(0, 0, 1);
      wt(8);
      wr(`EIDS_OFS_FLAGS, 16'h0000);
      rdc(`EIDS_OFS_FLAGS, 16'h0001, "unarmed clear");
      eids_pin_model_i.take(0);
      rdc(`EIDS_OFS_FLAGS, 16'h0000, "edge handled");
      p(0, 0, 0);
      p(0, 0, 1);
      wt(8);
      xfer(1'b1);
      rdc(`EIDS_OFS_FLAGS, 16'h0001, "transfer kept");
      xfer(1'b0);
      rdc(`EIDS_OFS_FLAGS, 16'h0000, "transfer clear");
      wr(`EIDS_OFS_SENSE, 16'h0000);
      p(0, 0, 0);
      wt(5);
      rdc(`EIDS_OFS_FLAGS, 16'h0001, "low level");
      eids_pin_model_i.serve(0);
      rdc(`EIDS_OFS_FLAGS, 16'h0000, "level handled");
   endtask
   task automatic t_pinsel();
      wr(`EIDS_OFS_SENSE, 16'h0010);
      wr(`EIDS_OFS_PINSEL, 16'h0004);
      p(0, 2, 0);
      wt(5);
      rdc(`EIDS_OFS_FLAGS, 16'h0000, "primary unused");
      p(1, 2, 0);
      wt(5);
      rdc(`EIDS_OFS_FLAGS, 16'h0004, "alternate");
      p(0, 2, 1);
      p(1, 2, 1);
      wt(5);
      clr(16'h0004);
   endtask
   task automatic t_wake();
      int i;
      wr(`EIDS_OFS_SENSE, 16'h0041);
      wr(`EIDS_OFS_EVSTAT, 16'h01ff);
      wr(`EIDS_OFS_EVMASK, 16'h0100);
      standbyActive <= 1'b1;
      p(0, 3, 0);
      p(0, 3, 1);
      wt(5);
      rdc(`EIDS_OFS_FLAGS, 16'h0000, "not sampled");
      p(0, 0, 0);
      for (i = 0; i < 40 && standbyExit !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      if (i == 40) begin
         errors++;
         end_sim();
      end
      chk(16'(i > SETTLE), 16'h0001, "settle wait");
      chk(16'(irq), 16'h0001, "irq raised");
      // leave standby on a clock edge, like every other input
      @(posedge mclk);
      standbyActive <= 1'b0;
      wr(`EIDS_OFS_EVMASK, 16'h0000);
      #1 chk(16'(irq), 16'h0000, "irq masked");
      wr(`EIDS_OFS_EVSTAT, 16'h0100);
      wr(`EIDS_OFS_EVMASK, 16'h0100);
      #1 chk(16'(irq), 16'h0000, "irq cleared");
      rdc(`EIDS_OFS_EVSTAT, 16'h0001, "event status");
      p(0, 0, 1);
      clr(16'h0001);
   endtask
   // reset, then each scenario in turn
   initial begin
      wt(12);
      rst_n <= 1'b1;
      t_regs();
      t_edges();
      t_auto();
      t_pinsel();
      t_wake();
      end_sim();
   end
endmodule
